// ---- rtl/gate_pkg.sv ----
// Purpose: shared constants and types for the external debug access gate
// Assumes: 8-bit byte address, 32-bit data, classic Wishbone slave
// Notes: offsets are byte addresses of aligned words
package gate_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int STICKY_W = 2;

    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] DBG_OFS = 8'h40;
    localparam logic [7:0] MON_OFS = 8'h80;

    // field positions
    localparam int CTRL_OS_LOCKED_CONDITION_BIT = 0;
    localparam int STAT_PU_BIT = 0;
    localparam int STAT_DLK_BIT = 1;
    localparam int STAT_OS_LOCKED_CONDITION_BIT = 2;
    localparam int STAT_STICKY_LSB = 3;
    localparam int FLAG_DBG = 0;
    localparam int FLAG_MON = 1;

    // reset values
    localparam logic OS_LOCKED_CONDITION_RST = 1'b1;
    localparam logic [STICKY_W-1:0] MASK_RST = 2'b00;
    localparam logic [DATA_W-1:0] DBG_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MON_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        V_OFF,
        V_DLK,
        V_OS_LOCKED_CONDITION,
        V_AUTH,
        V_OK
    } verdict_t;

    typedef enum logic [2:0] {
        R_CTRL,
        R_STAT,
        R_MASK,
        R_DBG,
        R_MON,
        R_NONE
    } region_t;

endpackage : gate_pkg

// ---- rtl/perm_check.sv ----
// Purpose: priority check of one external access against lock and power state
// Assumes: all inputs are current-cycle levels
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module perm_check (
    input wire logic core_powered,
    input wire logic double_locked,
    input wire logic os_locked,
    input wire logic access_allowed,
    output gate_pkg::verdict_t verdict,
    output logic deny
);
    import gate_pkg::*;

    always_comb begin
        if (!core_powered) begin
            verdict = V_OFF;
        end else if (double_locked) begin
            verdict = V_DLK;
        end else if (os_locked) begin
            verdict = V_OS_LOCKED_CONDITION;
        end else if (!access_allowed) begin
            verdict = V_AUTH;
        end else begin
            verdict = V_OK;
        end
        deny = (verdict != V_OK);
    end

endmodule : perm_check
`default_nettype wire

// ---- rtl/sticky_flags.sv ----
// Purpose: sticky event bits, cleared by writing one
// Assumes: set and clear are one-cycle pulses
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
module sticky_flags #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule : sticky_flags
`default_nettype wire

// ---- rtl/ext_debug_access_gate.sv ----
// Purpose: gate external register accesses by power, locks and authentication
// Assumes: single clock, inputs synchronous, classic Wishbone master
// Notes: gate control registers stay reachable; debug and monitor windows are gated
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module ext_debug_access_gate #(
    parameter int DW = gate_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic cold_poweron_reset_n,
    input wire logic ext_debug_if_reset_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [gate_pkg::ADDR_W-1:0] adr_i,
    input wire logic [gate_pkg::DATA_W-1:0] dat_i,
    input wire logic [gate_pkg::SEL_W-1:0] sel_i,
    output logic [gate_pkg::DATA_W-1:0] dat_o,
    output logic ack_o,
    output logic err_o,
    input wire logic core_powered_status_bit,
    input wire logic double_lock_status_bit,
    input wire logic ext_debug_allowed_fn,
    input wire logic ext_monitor_allowed_fn,
    input wire logic sys_os_locked_condition_we,
    input wire logic sys_os_locked_condition_wdata,
    input wire logic sys_dbg_we,
    input wire logic [gate_pkg::DATA_W-1:0] sys_dbg_wdata,
    input wire logic sys_mon_we,
    input wire logic [gate_pkg::DATA_W-1:0] sys_mon_wdata,
    output logic os_lock_status_bit,
    output logic [gate_pkg::DATA_W-1:0] dbg_data_o,
    output logic [gate_pkg::DATA_W-1:0] mon_data_o,
    output logic irq
);
    import gate_pkg::*;

    function automatic region_t decode(input logic [ADDR_W-1:0] a);
        case (a)
            CTRL_OFS: decode = R_CTRL;
            STAT_OFS: decode = R_STAT;
            MASK_OFS: decode = R_MASK;
            DBG_OFS: decode = R_DBG;
            MON_OFS: decode = R_MON;
            default: decode = R_NONE;
        endcase
    endfunction : decode

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [SEL_W-1:0] sel
    );
        merge = old_v;
        for (int b = 0; b < SEL_W; b++) begin
            if (sel[b]) begin
                merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    endfunction : merge

    // resets
    logic core_rst;
    logic bus_rst;
    assign core_rst = srst | ~cold_poweron_reset_n;
    assign bus_rst = core_rst | ~ext_debug_if_reset_n;

    // state
    logic os_locked_condition_q, os_locked_condition_d;
    logic [STICKY_W-1:0] mask_q, mask_d;
    logic [DATA_W-1:0] dbg_q, dbg_d;
    logic [DATA_W-1:0] mon_q, mon_d;
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic [DATA_W-1:0] dat_q, dat_d;

    // decision
    logic req;
    region_t region;
    logic gated_dbg, gated_mon;
    verdict_t dbg_verdict, mon_verdict;
    logic dbg_deny, mon_deny;
    logic bad;
    logic wr_ok, rd_ok;
    logic [STICKY_W-1:0] flag_set, flag_clr, flags;

    assign req = cyc_i & stb_i & ~ack_q & ~err_q;
    assign region = decode(adr_i);
    assign gated_dbg = (region == R_DBG);
    assign gated_mon = (region == R_MON);

    // judged on the live state in the request cycle
    perm_check u_dbg_check (
        .core_powered(core_powered_status_bit),
        .double_locked(double_lock_status_bit),
        .os_locked(os_locked_condition_q),
        .access_allowed(ext_debug_allowed_fn),
        .verdict(dbg_verdict),
        .deny(dbg_deny)
    );

    perm_check u_mon_check (
        .core_powered(core_powered_status_bit),
        .double_locked(double_lock_status_bit),
        .os_locked(os_locked_condition_q),
        .access_allowed(ext_monitor_allowed_fn),
        .verdict(mon_verdict),
        .deny(mon_deny)
    );

    always_comb begin
        bad = 1'b0;
        if (region == R_NONE) begin
            bad = 1'b1;
        end else if (gated_dbg) begin
            bad = dbg_deny;
        end else if (gated_mon) begin
            bad = mon_deny | we_i;
        end
        wr_ok = req & we_i & ~bad;
        rd_ok = req & ~we_i & ~bad;
    end

    // sticky error flags and interrupt
    always_comb begin
        flag_set = '0;
        flag_set[FLAG_DBG] = req & gated_dbg & (dbg_verdict == V_AUTH);
        flag_set[FLAG_MON] = req & gated_mon & (mon_verdict == V_AUTH);
        flag_clr = '0;
        if (wr_ok && region == R_STAT && sel_i[0]) begin
            flag_clr = dat_i[STAT_STICKY_LSB +: STICKY_W];
        end
    end

    sticky_flags #(
        .W(STICKY_W)
    ) u_flags (
        .clk(clk),
        .srst(core_rst),
        .set(flag_set),
        .clr(flag_clr),
        .flags(flags)
    );

    // register updates
    always_comb begin
        os_locked_condition_d = os_locked_condition_q;
        mask_d = mask_q;
        dbg_d = dbg_q;
        mon_d = mon_q;
        if (sys_os_locked_condition_we) begin
            os_locked_condition_d = sys_os_locked_condition_wdata;
        end
        if (sys_dbg_we) begin
            dbg_d = sys_dbg_wdata;
        end
        if (sys_mon_we) begin
            mon_d = sys_mon_wdata;
        end
        if (wr_ok && sel_i[0]) begin
            case (region)
                R_CTRL: os_locked_condition_d = dat_i[CTRL_OS_LOCKED_CONDITION_BIT];
                R_MASK: mask_d = dat_i[STICKY_W-1:0];
                default: begin
                end
            endcase
        end
        if (wr_ok && region == R_DBG) begin
            dbg_d = merge(dbg_q, dat_i, sel_i);
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            os_locked_condition_q <= OS_LOCKED_CONDITION_RST;
            mask_q <= MASK_RST;
            dbg_q <= DBG_RST;
            mon_q <= MON_RST;
        end else begin
            os_locked_condition_q <= os_locked_condition_d;
            mask_q <= mask_d;
            dbg_q <= dbg_d;
            mon_q <= mon_d;
        end
    end

    // bus answer
    always_comb begin
        ack_d = req & ~bad;
        err_d = req & bad;
        dat_d = '0;
        if (rd_ok) begin
            case (region)
                R_CTRL: dat_d[CTRL_OS_LOCKED_CONDITION_BIT] = os_locked_condition_q;
                R_STAT: begin
                    dat_d[STAT_PU_BIT] = core_powered_status_bit;
                    dat_d[STAT_DLK_BIT] = double_lock_status_bit;
                    dat_d[STAT_OS_LOCKED_CONDITION_BIT] = os_locked_condition_q;
                    dat_d[STAT_STICKY_LSB +: STICKY_W] = flags;
                end
                R_MASK: dat_d[STICKY_W-1:0] = mask_q;
                R_DBG: dat_d = dbg_q;
                R_MON: dat_d = mon_q;
                default: dat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (bus_rst) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            dat_q <= dat_d;
        end
    end

    assign ack_o = ack_q;
    assign err_o = err_q;
    assign dat_o = dat_q;
    assign os_lock_status_bit = os_locked_condition_q;
    assign dbg_data_o = dbg_q;
    assign mon_data_o = mon_q;
    assign irq = |(flags & mask_q);

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (bus_rst);

    sequence s_err_pulse;
        err_o && !ack_o ##1 !err_o;
    endsequence

    sequence s_ack_pulse;
        ack_o && !err_o ##1 !ack_o;
    endsequence

    property p_refused;
        req && bad |=> s_err_pulse;
    endproperty

    off_error_a: assert property (
        req && (gated_dbg || gated_mon) && !core_powered_status_bit |=> s_err_pulse
    ) else $error("unpowered gated access not refused");

    dlk_priority_a: assert property (
        req && gated_dbg && core_powered_status_bit && double_lock_status_bit
        |=> err_o && !$rose(flags[FLAG_DBG])
    ) else $error("double lock not taking priority");

    dbg_sticky_a: assert property (
        req && gated_dbg && core_powered_status_bit && !double_lock_status_bit
        && !os_locked_condition_q && !ext_debug_allowed_fn |=> err_o && flags[FLAG_DBG]
    ) else $error("debug sticky error not set");

    mon_sticky_a: assert property (
        req && gated_mon && core_powered_status_bit && !double_lock_status_bit
        && !os_locked_condition_q && !ext_monitor_allowed_fn |=> err_o && flags[FLAG_MON]
    ) else $error("monitor sticky error not set");

    os_locked_condition_quiet_a: assert property (
        req && gated_mon && core_powered_status_bit && !double_lock_status_bit
        && os_locked_condition_q |=> err_o && $stable(flags[FLAG_MON])
    ) else $error("os lock not refusing monitor access");

    dbg_read_a: assert property (
        req && gated_dbg && !we_i && !dbg_deny |=> s_ack_pulse and (dat_o == $past(dbg_q))
    ) else $error("permitted debug read wrong");

    mon_ro_a: assert property (
        req && gated_mon && we_i && !sys_mon_we |=> err_o && mon_q == $past(mon_q)
    ) else $error("monitor register written from outside");

    refused_err_a: assert property (p_refused)
        else $error("refused access not answered by err");

    cold_os_locked_condition_a: assert property (
        @(posedge clk) disable iff (srst)
        !cold_poweron_reset_n |=> os_locked_condition_q
    ) else $error("cold reset did not set os lock");

endmodule : ext_debug_access_gate
`default_nettype wire

// ---- tb/wb_master.sv ----
// Purpose: classic Wishbone master standing in for the debug interconnect
// Assumes: slave answers each request with ack or err
// Notes: one outstanding transfer; bounded wait for the answer
`timescale 1ns/100ps
`default_nettype none
module wb_master (
    input wire logic clk,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [31:0] wdat,
    output logic [3:0] sel,
    input wire logic [31:0] rdat,
    input wire logic ack,
    input wire logic err
);
    initial begin
        {cyc, stb, we, adr, wdat, sel} = '0;
    end

    // one transfer; request held until ack or err is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e,
                        output logic t);
        int n;
        t = 1'b1;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (ack === 1'b1 || err === 1'b1) begin
                t = 1'b0;
                break;
            end
        end
        q = rdat;
        e = err;
        {cyc, stb} <= 2'b00;
        wdat <= ~d;
    endtask : xfer
endmodule : wb_master
`default_nettype wire

// ---- tb/ext_debug_access_gate_tb.sv ----
// Purpose: self-checking bench of the external debug access gate
// Assumes: bus master model answers through xfer
// Notes: permission table walked for both gated windows
`timescale 1ns/100ps
`default_nettype none
module ext_debug_access_gate_tb;
    import gate_pkg::*;
    localparam logic [31:0] DBGV = 32'h1234_5678;
    localparam logic [31:0] MONV = 32'h9ABC_DEF0;
    logic clk, srst, cold_n, ext_n, cyc, stb, we, ack, err, irq, osl;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, dbg, mon;
    logic [3:0] sel;
    logic pu, dl, da, ma, so_we, so_d, sd_we, sm_we;
    logic [31:0] sd_d, sm_d;
    int fails = 0;
    int checks_done = 0;
    int k;
    logic r, st, dn;

    wb_master m_u (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .wdat(wdat),
        .sel(sel), .rdat(rdat), .ack(ack), .err(err));
    ext_debug_access_gate dut_u (.clk(clk), .srst(srst), .cold_poweron_reset_n(cold_n),
        .ext_debug_if_reset_n(ext_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .err_o(err),
        .core_powered_status_bit(pu), .double_lock_status_bit(dl),
        .ext_debug_allowed_fn(da), .ext_monitor_allowed_fn(ma), .sys_os_locked_condition_we(so_we),
        .sys_os_locked_condition_wdata(so_d), .sys_dbg_we(sd_we), .sys_dbg_wdata(sd_d),
        .sys_mon_we(sm_we), .sys_mon_wdata(sm_d), .os_lock_status_bit(osl),
        .dbg_data_o(dbg), .mon_data_o(mon), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic ee, input logic [31:0] eq);
        logic [31:0] q;
        logic e;
        logic t;
        m_u.xfer(w, a, d, s, q, e, t);
        if (t) begin
            fails++;
            close_out();
        end
        chk("err", {31'h0, ee}, {31'h0, e});
        if (!w && !ee) chk("rdata", eq, q);
    endtask : op

    task automatic setin(input logic p, input logic l, input logic x, input logic y);
        @(posedge clk);
        {pu, dl, da, ma} <= {p, l, x, y};
    endtask : setin

    task automatic pulse_rst(input logic cold);
        @(posedge clk);
        if (cold) cold_n <= 1'b0;
        else ext_n <= 1'b0;
        repeat (2) @(posedge clk);
        {cold_n, ext_n} <= 2'b11;
        @(posedge clk);
    endtask : pulse_rst

    initial begin
        {srst, cold_n, ext_n, pu, dl, da, ma} = 7'b1111011;
        {so_we, so_d, sd_we, sm_we, sd_d, sm_d} = '0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("os_locked_condition", 32'h1, {31'h0, osl});
        op(1'b0, DBG_OFS, '0, 4'hF, 1'b1, '0);
        {sd_we, sm_we, sd_d, sm_d} <= {2'b11, DBGV, MONV};
        @(posedge clk);
        {sd_we, sm_we} <= 2'b00;
        @(posedge clk);
        chk("dbg", DBGV, dbg);
        chk("mon", MONV, mon);
        for (k = 0; k < 32; k++) begin
            r = k[4];
            dn = !k[0] || k[1] || k[2] || !k[3];
            st = k[0] && !k[1] && !k[2] && !k[3];
            op(1'b1, CTRL_OFS, {31'h0, k[2]}, 4'hF, 1'b0, '0);
            op(1'b1, STAT_OFS, 32'h0000_0018, 4'hF, 1'b0, '0);
            setin(k[0], k[1], k[3] ^ r, k[3] ^ !r);
            op(1'b0, r ? MON_OFS : DBG_OFS, '0, 4'hF, dn, r ? MONV : DBGV);
            op(1'b0, STAT_OFS, '0, 4'hF, 1'b0,
                {27'h0, r & st, !r & st, k[2], k[1], k[0]});
        end
        op(1'b1, CTRL_OFS, '0, 4'hF, 1'b0, '0);
        op(1'b1, STAT_OFS, 32'h0000_0018, 4'hF, 1'b0, '0);
        setin(1'b1, 1'b0, 1'b1, 1'b1);
        op(1'b1, DBG_OFS, 32'hAABB_CCDD, 4'h3, 1'b0, '0);
        chk("dbg", 32'h1234_CCDD, dbg);
        op(1'b1, MON_OFS, 32'h0000_0001, 4'hF, 1'b1, '0);
        chk("mon", MONV, mon);
        setin(1'b1, 1'b0, 1'b0, 1'b1);
        op(1'b1, MASK_OFS, 32'h0000_0001, 4'hF, 1'b0, '0);
        op(1'b1, DBG_OFS, 32'h0000_0000, 4'hF, 1'b1, '0);
        chk("dbg", 32'h1234_CCDD, dbg);
        chk("irq", 32'h1, {31'h0, irq});
        op(1'b1, STAT_OFS, 32'h0000_0008, 4'hF, 1'b0, '0);
        chk("irq", 32'h0, {31'h0, irq});
        op(1'b1, MASK_OFS, 32'h0000_0000, 4'hF, 1'b0, '0);
        op(1'b0, DBG_OFS, '0, 4'hF, 1'b1, '0);
        chk("irq", 32'h0, {31'h0, irq});
        setin(1'b0, 1'b0, 1'b1, 1'b1);
        op(1'b0, DBG_OFS, '0, 4'hF, 1'b1, '0);
        op(1'b0, 8'h0C, '0, 4'hF, 1'b1, '0);
        {so_we, so_d} <= 2'b11;
        @(posedge clk);
        so_we <= 1'b0;
        @(posedge clk);
        chk("os_locked_condition", 32'h1, {31'h0, osl});
        op(1'b1, CTRL_OFS, '0, 4'hF, 1'b0, '0);
        chk("os_locked_condition", 32'h0, {31'h0, osl});
        pulse_rst(1'b0);
        chk("os_locked_condition", 32'h0, {31'h0, osl});
        chk("dbg", 32'h1234_CCDD, dbg);
        pulse_rst(1'b1);
        chk("os_locked_condition", 32'h1, {31'h0, osl});
        chk("dbg", 32'h0, dbg);
        chk("mon", 32'h0, mon);
        close_out();
    end
endmodule : ext_debug_access_gate_tb
`default_nettype wire
